// *** core/power_mode_pkg.sv ***
// constants, types and register map of the power-mode and wake controller
// assumes a single 250 MHz clock and an Avalon-MM register slave
package power_mode_pkg;

    // timing
    localparam int CLK_FREQ_MHZ    = 250;
    localparam int SECOND_US       = 1000000;
    localparam int SECOND_CYCLES   = SECOND_US * CLK_FREQ_MHZ;
    localparam int SWITCH_HOLD_NS  = 10000;
    localparam int SWITCH_HOLD_CYC = SWITCH_HOLD_NS * CLK_FREQ_MHZ / 1000;
    localparam int CORE_RST_NS     = 100;
    localparam int CORE_RST_CYC    = (CORE_RST_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam logic [16:0] SECONDS_PER_DAY = 17'h1_5180;

    // register byte addresses
    localparam logic [7:0] ADDR_PULLUP_DIS = 8'h00;
    localparam logic [7:0] ADDR_WAKE_EN    = 8'h04;
    localparam logic [7:0] ADDR_TEMP_STEP  = 8'h08;
    localparam logic [7:0] ADDR_TEMP_IVAL  = 8'h0c;
    localparam logic [7:0] ADDR_ALARM      = 8'h10;
    localparam logic [7:0] ADDR_CONTROL    = 8'h14;
    localparam logic [7:0] ADDR_RTC_SEC    = 8'h18;
    localparam logic [7:0] ADDR_TEMP_REF   = 8'h1c;
    localparam logic [7:0] ADDR_PM_FLAGS   = 8'hf8;

    // reset values
    localparam logic [7:0] PULLUP_DIS_RST = 8'h00;
    localparam logic [3:0] WAKE_EN_RST    = 4'h0;
    localparam logic [7:0] TEMP_STEP_RST  = 8'h04;
    localparam logic [7:0] TEMP_IVAL_RST  = 8'h3c;

    // field positions
    localparam int PULLUP_SCL_BIT = 6;
    localparam int PULLUP_SDA_BIT = 4;
    localparam int WEN_ALARM      = 0;
    localparam int WEN_TEMP       = 1;
    localparam int WEN_IRQ0       = 2;
    localparam int WEN_IRQ1       = 3;
    localparam int CTL_SLEEP      = 0;
    localparam int CTL_DISP_EN    = 1;
    localparam int CTL_DISP_BLINK = 2;
    localparam int FLG_BATTERY    = 0;
    // wake cause bits 7:1 of the flag register
    localparam int CAUSE_MIDNIGHT = 0;
    localparam int CAUSE_ALARM    = 1;
    localparam int CAUSE_LINE     = 2;
    localparam int CAUSE_RX       = 3;
    localparam int CAUSE_TEMP     = 4;
    localparam int CAUSE_IRQ      = 5;
    localparam int CAUSE_RESET    = 6;

    typedef enum logic [1:0] {
        line_power_mode,
        battery_run_mode,
        battery_sleep_mode
    } mode_type;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avalon_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avalon_rsp_type;

    typedef struct packed {
        logic line_ok;
        logic battery_ok;
        logic bulk_low;
    } supply_sense_type;

    typedef struct packed {
        logic line_supply_en;
        logic switched_supply_en;
        logic internal_digital_supply_en;
        logic core_en;
        logic core_reset;
        logic metering_en;
    } supply_ctl_type;

endpackage

// *** core/power_mode_wake_control.sv ***
// power-mode sequencer, wake logic, rtc seconds counter and pin pull-up control
// assumes synchronous inputs, one clock, Avalon-MM master with waitrequest
//
// How it works
// - line supply enable is high only in line power mode
// - switched supply on while line or battery valid
// - digital supply on in run modes, off in sleep
// - sleep mode turns off metering logic and the core
// - rtc seconds counter runs in every mode
// - display may stay on in sleep, steady or blinking
// - temperature sample every programmed interval in sleep
// - enabled wake event moves sleep to battery run, line return to line power
// - rtc midnight always wakes the device
// - rtc alarm match wakes when its enable is set
// - line return switches back and wakes the device
// - serial receive activity wakes the device
// - temperature step above limit wakes when enabled
// - each external interrupt wakes when enabled
// - external reset always wakes the device
// - wake restores digital supply, pulses core reset
// - flag register bit shows line or battery switch position
// - software can command battery sleep from battery run
// - every pin pull-up can be disabled individually
// - two-wire pins open-drain while core runs
// - in sleep two-wire pull-ups on unless disabled
// - pull-up register bit 6 disables clock, bit 4 data pull-up
// - battery turns off metering converters and logic
// - switch-back needs line valid for a hold time
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module power_mode_wake_control
    import power_mode_pkg::*;
#(
    parameter int SEC_CYCLES = power_mode_pkg::SECOND_CYCLES
) (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            resetn,
    // register bus
    input  wire power_mode_pkg::avalon_req_type  bus_req,
    output      power_mode_pkg::avalon_rsp_type  bus_rsp,
    // supply sense and control
    input  wire power_mode_pkg::supply_sense_type sense,
    output      power_mode_pkg::supply_ctl_type  supply,
    output      logic                            on_battery,
    output      power_mode_pkg::mode_type        mode,
    // wake sources
    input  wire logic                            rx_in,
    input  wire logic                            ext_irq_zero,
    input  wire logic                            ext_irq_one,
    input  wire logic                            ext_reset_n,
    // temperature converter
    input  wire logic                            temp_ready,
    input  wire logic [7:0]                      temp_value,
    output      logic                            temp_start,
    // display
    output      logic                            display_en,
    output      logic                            display_blank,
    // pins: pull-ups and two-wire open drain
    input  wire logic                            twowire_enable,
    input  wire logic                            scl_drive_low,
    input  wire logic                            twowire_data_drive_low,
    input  wire logic                            scl_in,
    input  wire logic                            twowire_data_pin_in,
    output      logic [7:0]                      pullup_en,
    output      logic                            scl_out,
    output      logic                            scl_oe_n,
    output      logic                            twowire_data_pin_out,
    output      logic                            twowire_data_pin_oe_n,
    output      logic                            scl_seen,
    output      logic                            twowire_data_seen
);
    import power_mode_pkg::*;

    typedef struct packed {
        mode_type       mode;
        avalon_rsp_type rsp;
        supply_ctl_type supply;
        logic [7:0]     pullup_dis;
        logic [3:0]     wake_en;
        logic [2:0]     control;
        logic [7:0]     temp_step;
        logic [7:0]     temp_ival;
        logic [7:0]     temp_ref;
        logic [7:0]     temp_cnt;
        logic [16:0]    alarm;
        logic [16:0]    sec_of_day;
        logic [31:0]    div;
        logic [11:0]    hold_cnt;
        logic [4:0]     core_rst_cnt;
        logic           on_battery;
        logic [6:0]     wake_cause;
        logic           temp_start;
        logic           display_en;
        logic           display_blank;
        logic [7:0]     pullup_en;
        logic           scl_oe_n;
        logic           sda_oe_n;
        logic           scl_seen;
        logic           sda_seen;
    } state_type;

    localparam logic [31:0] SEC_LAST  = 32'(SEC_CYCLES - 1);
    localparam logic [11:0] HOLD_LAST = 12'(SWITCH_HOLD_CYC - 1);
    localparam logic [4:0]  RST_LOAD  = 5'(CORE_RST_CYC);

    state_type st_r;
    state_type st_nxt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    always_comb begin
        logic       tick;
        logic       midnight;
        logic       ev_alarm;
        logic       ev_line;
        logic       ev_temp;
        logic       sleep_cmd;
        logic       asleep;
        logic [6:0] events;
        logic [6:0] cause_clr;
        logic [7:0] diff;
        logic       wr;
        tick      = 1'b0;
        midnight  = 1'b0;
        ev_alarm  = 1'b0;
        ev_line   = 1'b0;
        ev_temp   = 1'b0;
        sleep_cmd = 1'b0;
        events    = 7'h00;
        cause_clr = 7'h00;
        diff      = 8'h00;
        wr        = 1'b0;
        asleep    = st_r.mode == battery_sleep_mode;
        st_nxt    = st_r;
        st_nxt.temp_start = 1'b0;

        // one second enable; rtc never stops
        tick = st_r.div == SEC_LAST;
        st_nxt.div = tick ? 32'h0000_0000 : st_r.div + 32'h0000_0001;
        if (tick) begin
            midnight = st_r.sec_of_day == SECONDS_PER_DAY - 17'h0_0001;
            ev_alarm = st_r.sec_of_day == st_r.alarm && st_r.wake_en[WEN_ALARM];
            st_nxt.sec_of_day = midnight ? 17'h0_0000 : st_r.sec_of_day + 17'h0_0001;
        end

        // switch: battery at once, line only after a stable hold
        if (!sense.line_ok || sense.bulk_low) begin
            st_nxt.on_battery = 1'b1;
            st_nxt.hold_cnt   = 12'h000;
        end else if (st_r.on_battery) begin
            if (st_r.hold_cnt == HOLD_LAST) begin
                st_nxt.on_battery = 1'b0;
                ev_line           = 1'b1;
                st_nxt.hold_cnt   = 12'h000;
            end else begin
                st_nxt.hold_cnt = st_r.hold_cnt + 12'h001;
            end
        end

        // temperature sampling while asleep; compare against the last reference
        if (asleep && tick) begin
            if (st_r.temp_cnt + 8'h01 >= st_r.temp_ival) begin
                st_nxt.temp_cnt   = 8'h00;
                st_nxt.temp_start = 1'b1;
            end else begin
                st_nxt.temp_cnt = st_r.temp_cnt + 8'h01;
            end
        end
        if (temp_ready) begin
            diff = temp_value >= st_r.temp_ref ? temp_value - st_r.temp_ref
                                               : st_r.temp_ref - temp_value;
            if (diff > st_r.temp_step && st_r.wake_en[WEN_TEMP]) begin
                ev_temp         = 1'b1;
                st_nxt.temp_ref = temp_value;
            end
        end

        events[CAUSE_MIDNIGHT] = midnight;
        events[CAUSE_ALARM]    = ev_alarm;
        events[CAUSE_LINE]     = ev_line;
        events[CAUSE_RX]       = !rx_in;
        events[CAUSE_TEMP]     = ev_temp;
        events[CAUSE_IRQ]      = (ext_irq_zero && st_r.wake_en[WEN_IRQ0])
                              || (ext_irq_one && st_r.wake_en[WEN_IRQ1]);
        events[CAUSE_RESET]    = !ext_reset_n;

        // bus: one wait cycle, answer stands one cycle
        st_nxt.rsp.waitrequest = 1'b1;
        if (st_r.rsp.waitrequest && (bus_req.read || bus_req.write)) begin
            st_nxt.rsp.waitrequest = 1'b0;
            st_nxt.rsp.readdata    = 32'h0000_0000;
            if (bus_req.read) begin
                unique case (1'b1)
                    hit(bus_req.address, ADDR_PULLUP_DIS):
                        st_nxt.rsp.readdata[7:0] = st_r.pullup_dis;
                    hit(bus_req.address, ADDR_WAKE_EN):
                        st_nxt.rsp.readdata[3:0] = st_r.wake_en;
                    hit(bus_req.address, ADDR_TEMP_STEP):
                        st_nxt.rsp.readdata[7:0] = st_r.temp_step;
                    hit(bus_req.address, ADDR_TEMP_IVAL):
                        st_nxt.rsp.readdata[7:0] = st_r.temp_ival;
                    hit(bus_req.address, ADDR_ALARM):
                        st_nxt.rsp.readdata[16:0] = st_r.alarm;
                    hit(bus_req.address, ADDR_CONTROL):
                        st_nxt.rsp.readdata[2:0] = {st_r.control[2:1], 1'b0};
                    hit(bus_req.address, ADDR_RTC_SEC):
                        st_nxt.rsp.readdata[16:0] = st_r.sec_of_day;
                    hit(bus_req.address, ADDR_TEMP_REF):
                        st_nxt.rsp.readdata[7:0] = st_r.temp_ref;
                    hit(bus_req.address, ADDR_PM_FLAGS):
                        st_nxt.rsp.readdata[7:0] = {st_r.wake_cause, st_r.on_battery};
                    default:
                        st_nxt.rsp.readdata = 32'h0000_0000;
                endcase
            end
        end
        wr = bus_req.write && !st_r.rsp.waitrequest;
        if (wr) begin
            unique case (1'b1)
                hit(bus_req.address, ADDR_PULLUP_DIS):
                    st_nxt.pullup_dis = bus_req.writedata[7:0];
                hit(bus_req.address, ADDR_WAKE_EN):
                    st_nxt.wake_en = bus_req.writedata[3:0];
                hit(bus_req.address, ADDR_TEMP_STEP):
                    st_nxt.temp_step = bus_req.writedata[7:0];
                hit(bus_req.address, ADDR_TEMP_IVAL):
                    st_nxt.temp_ival = bus_req.writedata[7:0];
                hit(bus_req.address, ADDR_ALARM):
                    st_nxt.alarm = bus_req.writedata[16:0];
                hit(bus_req.address, ADDR_CONTROL): begin
                    st_nxt.control = bus_req.writedata[2:0];
                    sleep_cmd      = bus_req.writedata[CTL_SLEEP];
                end
                hit(bus_req.address, ADDR_RTC_SEC):
                    st_nxt.sec_of_day = bus_req.writedata[16:0];
                hit(bus_req.address, ADDR_TEMP_REF):
                    if (!ev_temp) begin
                        st_nxt.temp_ref = bus_req.writedata[7:0];
                    end
                hit(bus_req.address, ADDR_PM_FLAGS):
                    cause_clr = bus_req.writedata[7:1];
                default: ;
            endcase
        end

        // causes are caught only while asleep; a new cause beats a clear
        st_nxt.wake_cause = (st_r.wake_cause & ~cause_clr) | (asleep ? events : 7'h00);

        // mode sequencing
        unique case (st_r.mode)
            line_power_mode:
                if (st_nxt.on_battery) begin
                    st_nxt.mode = battery_run_mode;
                end
            battery_run_mode:
                if (!st_nxt.on_battery) begin
                    st_nxt.mode = line_power_mode;
                end else if (sleep_cmd) begin
                    st_nxt.mode = battery_sleep_mode;
                end
            battery_sleep_mode:
                if (!st_nxt.on_battery || events != 7'h00) begin
                    st_nxt.mode = st_nxt.on_battery ? battery_run_mode
                                                    : line_power_mode;
                    st_nxt.core_rst_cnt = RST_LOAD;
                end
        endcase
        if (st_r.core_rst_cnt != 5'h00 && st_r.mode != battery_sleep_mode) begin
            st_nxt.core_rst_cnt = st_r.core_rst_cnt - 5'h01;
        end

        // supplies follow the next mode; switched supply follows line or battery sense
        st_nxt.supply.line_supply_en  = st_nxt.mode == line_power_mode;
        st_nxt.supply.switched_supply_en = sense.line_ok || sense.battery_ok;
        st_nxt.supply.internal_digital_supply_en =
            st_nxt.mode != battery_sleep_mode;
        st_nxt.supply.core_en = st_nxt.mode != battery_sleep_mode;
        st_nxt.supply.metering_en = st_nxt.mode == line_power_mode;
        // core reset after a wake and while the reset pin is low
        st_nxt.supply.core_reset = st_nxt.core_rst_cnt != 5'h00 || !ext_reset_n;

        // display: always on in run, software choice in sleep
        if (st_nxt.mode == battery_sleep_mode) begin
            st_nxt.display_en    = st_r.control[CTL_DISP_EN];
            st_nxt.display_blank = st_r.control[CTL_DISP_EN]
                                && st_r.control[CTL_DISP_BLINK] && st_r.sec_of_day[0];
        end else begin
            st_nxt.display_en    = 1'b1;
            st_nxt.display_blank = 1'b0;
        end

        // two-wire pull-ups off while two-wire runs; in sleep on unless disabled
        st_nxt.pullup_en = ~st_r.pullup_dis;
        if (st_nxt.mode != battery_sleep_mode && twowire_enable) begin
            st_nxt.pullup_en[PULLUP_SCL_BIT] = 1'b0;
            st_nxt.pullup_en[PULLUP_SDA_BIT] = 1'b0;
        end else if (st_nxt.mode == battery_sleep_mode) begin
            st_nxt.pullup_en[PULLUP_SCL_BIT] = !st_r.pullup_dis[PULLUP_SCL_BIT];
            st_nxt.pullup_en[PULLUP_SDA_BIT] = !st_r.pullup_dis[PULLUP_SDA_BIT];
        end

        // open drain: only pull low, only while the core runs
        st_nxt.scl_oe_n = !(st_nxt.supply.core_en && twowire_enable && scl_drive_low);
        st_nxt.sda_oe_n = !(st_nxt.supply.core_en && twowire_enable
                         && twowire_data_drive_low);
        st_nxt.scl_seen = scl_in;
        st_nxt.sda_seen = twowire_data_pin_in;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r                 <= '0;
            st_r.mode            <= line_power_mode;
            st_r.rsp.waitrequest <= 1'b1;
            st_r.pullup_dis      <= PULLUP_DIS_RST;
            st_r.wake_en         <= WAKE_EN_RST;
            st_r.temp_step       <= TEMP_STEP_RST;
            st_r.temp_ival       <= TEMP_IVAL_RST;
            st_r.on_battery      <= 1'b1;
            st_r.core_rst_cnt    <= RST_LOAD;
            st_r.supply          <= '{core_reset: 1'b1, default: 1'b0};
            st_r.pullup_en       <= ~PULLUP_DIS_RST;
            st_r.scl_oe_n        <= 1'b1;
            st_r.sda_oe_n        <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rsp               = st_r.rsp;
    assign supply                = st_r.supply;
    assign on_battery            = st_r.on_battery;
    assign mode                  = st_r.mode;
    assign temp_start            = st_r.temp_start;
    assign display_en            = st_r.display_en;
    assign display_blank         = st_r.display_blank;
    assign pullup_en             = st_r.pullup_en;
    assign scl_out               = 1'b0;
    assign scl_oe_n              = st_r.scl_oe_n;
    assign twowire_data_pin_out  = 1'b0;
    assign twowire_data_pin_oe_n = st_r.sda_oe_n;
    assign scl_seen              = st_r.scl_seen;
    assign twowire_data_seen     = st_r.sda_seen;

endmodule

// *** bench/power_mode_wake_control_properties.sv ***
// port-level properties of the power-mode and wake controller
// bound into every power_mode_wake_control; one clock domain
`timescale 1ns/1ps
module power_mode_wake_control_properties
    import power_mode_pkg::*;
(
    // clock and reset
    input wire logic                             clk,
    input wire logic                             resetn,
    // watched ports
    input wire power_mode_pkg::avalon_req_type   bus_req,
    input wire power_mode_pkg::avalon_rsp_type   bus_rsp,
    input wire power_mode_pkg::supply_sense_type sense,
    input wire power_mode_pkg::supply_ctl_type   supply,
    input wire power_mode_pkg::mode_type         mode,
    input wire logic                             rx_in,
    input wire logic                             ext_reset_n,
    input wire logic                             twowire_enable,
    input wire logic                             scl_drive_low,
    input wire logic                             scl_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_line_only: assert property (supply.line_supply_en |-> mode == line_power_mode)
        else $error("line supply");
    a_switched_on: assert property ((sense.line_ok || sense.battery_ok) [*2] |-> supply.switched_supply_en)
        else $error("switched supply");
    a_sleep_off: assert property (mode == battery_sleep_mode |-> !supply.core_en && !supply.internal_digital_supply_en && !supply.metering_en)
        else $error("power in sleep");
    a_bus_answer: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest ##1 bus_rsp.waitrequest)
        else $error("bus answer");
    a_sleep_cmd: assert property (mode == battery_run_mode && bus_req.write && !bus_rsp.waitrequest && bus_req.address == ADDR_CONTROL && bus_req.writedata[CTL_SLEEP] && rx_in && ext_reset_n |=> mode == battery_sleep_mode)
        else $error("sleep command");
    a_wake_reset: assert property (mode == battery_run_mode && $past(mode) == battery_sleep_mode |-> (supply.internal_digital_supply_en && supply.core_reset) [*8])
        else $error("wake reset");
    a_rx_wake: assert property (mode == battery_sleep_mode && !rx_in |=> mode != battery_sleep_mode)
        else $error("rx wake");
    a_reset_wake: assert property (mode == battery_sleep_mode && !ext_reset_n |=> mode != battery_sleep_mode && supply.core_reset)
        else $error("reset wake");
    a_open_drain: assert property (mode != battery_sleep_mode && twowire_enable && scl_drive_low |=> !scl_oe_n)
        else $error("open drain");
endmodule

bind power_mode_wake_control power_mode_wake_control_properties i_power_mode_wake_control_properties (
    .clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rsp(bus_rsp), .sense(sense),
    .supply(supply), .mode(mode), .rx_in(rx_in), .ext_reset_n(ext_reset_n),
    .twowire_enable(twowire_enable), .scl_drive_low(scl_drive_low), .scl_oe_n(scl_oe_n));

// *** bench/supply_partner.sv ***
// model of line supply, backup battery and external wake sources
// bench commands it; its lines move just after a rising edge
`timescale 1ns/1ps
module supply_partner
    import power_mode_pkg::*;
(
    // clock and bench commands
    input  wire logic                     clk,
    input  wire logic                     line_up,
    input  wire logic [1:0]               irq_up,
    input  wire logic                     rx_busy,
    input  wire logic                     rst_press,
    // lines into the controller
    output power_mode_pkg::supply_sense_type sense,
    output logic                          rx_in,
    output logic                          ext_irq_zero,
    output logic                          ext_irq_one,
    output logic                          ext_reset_n
);
    initial begin
        sense = '{1'b1, 1'b1, 1'b0};
        rx_in = 1'b1;
        ext_irq_zero = 1'b0;
        ext_irq_one = 1'b0;
        ext_reset_n = 1'b1;
    end
    // battery never fails; bulk sense follows the line
    always @(posedge clk) begin
        sense <= '{line_up, 1'b1, !line_up};
        rx_in <= !rx_busy;
        ext_irq_zero <= irq_up[0];
        ext_irq_one <= irq_up[1];
        ext_reset_n <= !rst_press;
    end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the power-mode controller
// assumes the supply partner model and the bound property checker
`timescale 1ns/1ps
module tb;
    import power_mode_pkg::*;
    logic             clk, resetn, line_up, rx_busy, rst_press, on_battery;
    logic [1:0]       irq_up;
    avalon_req_type   bus_req;
    avalon_rsp_type   bus_rsp;
    supply_sense_type sense;
    supply_ctl_type   supply;
    mode_type         mode;
    logic             rx_in, ext_irq_zero, ext_irq_one, ext_reset_n;
    logic             twowire_enable, scl_drive_low, scl_oe_n, sda_oe_n, temp_ready;
    logic [7:0]       pullup_en;
    int               miscompares, comparisons, cyc = 0;

    supply_partner i_supply_partner (.clk(clk), .line_up(line_up), .irq_up(irq_up),
        .rx_busy(rx_busy), .rst_press(rst_press), .sense(sense), .rx_in(rx_in),
        .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one), .ext_reset_n(ext_reset_n));
    // each pin reads back its own drive
    power_mode_wake_control #(.SEC_CYCLES(20)) i_power_mode_wake_control (
        .clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rsp(bus_rsp), .sense(sense),
        .supply(supply), .on_battery(on_battery), .mode(mode), .rx_in(rx_in),
        .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one), .ext_reset_n(ext_reset_n),
        .temp_ready(temp_ready), .temp_value(8'h10), .temp_start(), .display_en(),
        .display_blank(), .twowire_enable(twowire_enable), .scl_drive_low(scl_drive_low),
        .twowire_data_drive_low(scl_drive_low), .scl_in(scl_oe_n),
        .twowire_data_pin_in(sda_oe_n), .pullup_en(pullup_en), .scl_out(),
        .scl_oe_n(scl_oe_n), .twowire_data_pin_out(), .twowire_data_pin_oe_n(sda_oe_n),
        .scl_seen(), .twowire_data_seen());

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // hangs are cut by the cycle ceiling below
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        bus_req <= '{a, !wr, wr, d};
        do @(posedge clk); while (bus_rsp.waitrequest !== 1'b0);
        q = bus_rsp.readdata;
        bus_req <= '0;
    endtask

    task automatic t_start();
        logic [7:0]  a [5] = '{ADDR_PULLUP_DIS, ADDR_WAKE_EN, ADDR_TEMP_STEP, ADDR_TEMP_IVAL, 8'h40};
        logic [31:0] e [5] = '{PULLUP_DIS_RST, WAKE_EN_RST, TEMP_STEP_RST, TEMP_IVAL_RST, 0};
        logic [31:0] q;
        foreach (a[i]) begin
            bus(1'b0, a[i], 32'h0000_0000, q);
            chk(q, e[i]);
        end
        bus(1'b0, ADDR_PM_FLAGS, 32'h0000_0000, q);
        chk(q[0], 1'b1);
        repeat (2000) @(posedge clk);
        chk(on_battery, 1'b1);
        repeat (700) if (on_battery !== 1'b0) @(posedge clk);
        chk({mode, supply.line_supply_en, supply.metering_en}, {line_power_mode, 2'b11});
        twowire_enable <= 1'b1;
        scl_drive_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk({scl_oe_n, sda_oe_n, pullup_en[6], pullup_en[4]}, 4'h0);
        twowire_enable <= 1'b0;
        scl_drive_low <= 1'b0;
        line_up <= 1'b0;
        repeat (4) @(posedge clk);
        chk({mode, supply.metering_en, on_battery}, {battery_run_mode, 2'b01});
        bus(1'b0, ADDR_PM_FLAGS, 32'h0000_0000, q);
        chk(q[0], 1'b1);
        bus(1'b1, ADDR_PULLUP_DIS, 32'h0000_0040, q);
    endtask

    task automatic t_wake(input int src, input logic [31:0] cause);
        logic [31:0] q;
        bus(1'b1, ADDR_CONTROL, 32'h0000_0001, q);
        @(posedge clk);
        chk({mode, supply.core_en, supply.switched_supply_en}, 4'b1001);
        chk(pullup_en, 8'hbf);
        case (src)
            0: rx_busy <= 1'b1;
            1: begin
                irq_up <= 2'b11;
                repeat (10) @(posedge clk);
                chk(mode, battery_sleep_mode);
                bus(1'b1, ADDR_WAKE_EN, 32'h0000_000c, q);
            end
            2: line_up <= 1'b1;
            3: rst_press <= 1'b1;
            6: begin
                bus(1'b1, ADDR_WAKE_EN, 32'h0000_0002, q);
                temp_ready <= 1'b1;
            end
            4: bus(1'b1, ADDR_RTC_SEC, 32'(SECONDS_PER_DAY) - 32'h0000_0002, q);
            default: begin
                bus(1'b0, ADDR_RTC_SEC, 32'h0000_0000, q);
                bus(1'b1, ADDR_ALARM, q + 32'h0000_0003, q);
                bus(1'b1, ADDR_WAKE_EN, 32'h0000_0001, q);
            end
        endcase
        repeat (3000) if (mode === battery_sleep_mode) @(posedge clk);
        chk({supply.core_en, supply.core_reset}, 2'b11);
        rx_busy <= 1'b0;
        irq_up <= 2'b00;
        line_up <= 1'b0;
        rst_press <= 1'b0;
        temp_ready <= 1'b0;
        repeat (40) @(posedge clk);
        bus(1'b0, ADDR_PM_FLAGS, 32'h0000_0000, q);
        chk(q & cause, cause);
        bus(1'b1, ADDR_PM_FLAGS, cause, q);
        bus(1'b0, ADDR_PM_FLAGS, 32'h0000_0000, q);
        chk(q & cause, 32'h0000_0000);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        resetn = 1'b0;
        bus_req = '0;
        line_up = 1'b1;
        irq_up = 2'b00;
        rx_busy = 1'b0;
        temp_ready = 1'b0;
        rst_press = 1'b0;
        twowire_enable = 1'b0;
        scl_drive_low = 1'b0;
        miscompares = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_start();
        t_wake(0, 32'h0000_0010);
        t_wake(1, 32'h0000_0040);
        t_wake(4, 32'h0000_0002);
        t_wake(5, 32'h0000_0004);
        t_wake(2, 32'h0000_0008);
        t_wake(3, 32'h0000_0080);
        t_wake(6, 32'h0000_0020);
        stop_test();
    end
endmodule
